/* File: hw/tmv_defs.svh */
// Constants of the transient mitigation voter: offsets, fields, resets, timing
// How it works
// - Two of three lows on two generators
// - Level at or below threshold counts low
// - Start needs vote plus load permissive
// - Load threshold is a software constant
// - Configured delay before any output
// - All trip and start outputs together
// - Low load blocks mitigation
// - Block defeated 360 s after load drop
// - Vote during hold still initiates
// - One controller per steam generator
`ifndef TMV_DEFS_SVH
`define TMV_DEFS_SVH
// APB byte offsets
`define TMV_OFF_CTRL      12'h000
`define TMV_OFF_LEVEL_THR 12'h004
`define TMV_OFF_LOAD_THR  12'h008
`define TMV_OFF_DELAY     12'h00C
`define TMV_OFF_STATUS    12'h010
`define TMV_OFF_IRQ_STAT  12'h014
`define TMV_OFF_IRQ_MASK  12'h018
// Interrupt status bit positions
`define TMV_IRQ_LOF   0
`define TMV_IRQ_FIRE  1
`define TMV_IRQ_BLOCK 2
// Reset values
`define TMV_RST_ARM       1'b1
`define TMV_RST_LEVEL_THR 16'h2000
`define TMV_RST_LOAD_THR  16'h6000
`define TMV_RST_DELAY     32'h0000_0400
`define TMV_RST_MASK      3'h0
// Hold time after load drop
`define TMV_CLK_HZ 64'h0000_0000_0773_5940
`define TMV_HOLD_S 64'h0000_0000_0000_0168
`define TMV_HOLD_CYC (`TMV_HOLD_S * `TMV_CLK_HZ)
`endif

/* File: hw/tmv_pkg.sv */
// Types of the transient mitigation voter
package tmv_pkg;
   typedef logic [15:0] tmv_level_t;
   typedef logic [35:0] tmv_hold_t;
   // Controller states, Gray along idle, delay, fired
   typedef enum logic [1:0] {
      TMV_IDLE  = 2'h0,
      TMV_DELAY = 2'h1,
      TMV_FIRED = 2'h3
   } tmv_state_e;
   // Per-generator controller state
   typedef struct packed {
      tmv_state_e  state;
      tmv_hold_t   hold_cnt;
      logic [31:0] dly_cnt;
      logic        load_prev;
      logic        fire;
      logic        perm;
   } tmv_ctrl_s;
   // Top state: registers, bus answer, outputs
   typedef struct packed {
      logic        arm;
      tmv_level_t  level_thr;
      tmv_level_t  load_thr;
      logic [31:0] delay;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic        turbine_trip;
      logic [2:0]  feed_pump_start;
      logic        blowdown_close;
      logic        sample_close;
      logic [1:0]  mg_breaker_trip;
      logic        prev_lof;
      logic        prev_fire;
      logic        prev_perm;
   } tmv_top_s;
endpackage

/* File: hw/tmv_voter.sv */
// Transient mitigation voter: per-generator controllers and APB top
`timescale 1ns/1ps
`include "tmv_defs.svh"

////////////////////////////////////////////////////////////////////////////
// One controller per steam generator
module tmv_sg_ctrl
#(
   parameter tmv_pkg::tmv_hold_t HOLD_CYCLES = 36'h0_0000_0001
)
(
   input  wire logic               clk_sys,
   input  wire logic               rst_b,
   input  wire tmv_pkg::tmv_level_t lvl_a,
   input  wire tmv_pkg::tmv_level_t lvl_b,
   input  wire tmv_pkg::tmv_level_t lvl_c,
   input  wire tmv_pkg::tmv_level_t level_thr,
   input  wire tmv_pkg::tmv_level_t first_stage_pressure_a,
   input  wire tmv_pkg::tmv_level_t first_stage_pressure_b,
   input  wire tmv_pkg::tmv_level_t load_thr,
   input  wire logic [31:0]        delay,
   input  wire logic               arm,
   input  wire logic               lof,
   output logic                    sg_low,
   output logic                    perm,
   output logic                    fire
);
   tmv_pkg::tmv_ctrl_s r;       // Registered state
   tmv_pkg::tmv_ctrl_s next_r;  // Next state
   logic [2:0] low;             // Per channel low flags
   logic       load_above;      // Either pressure over threshold
   logic       start;           // Start condition

   assign low[0] = (lvl_a <= level_thr);
   assign low[1] = (lvl_b <= level_thr);
   assign low[2] = (lvl_c <= level_thr);

   assign sg_low = (low[0] & low[1]) | (low[0] & low[2]) | (low[1] & low[2]);

   assign load_above = (first_stage_pressure_a > load_thr) | (first_stage_pressure_b > load_thr);

   assign perm = r.perm;
   assign fire = r.fire;

   // Next state of hold timer, delay timer and sequence
   always_comb
   begin
      next_r = r;
      next_r.load_prev = load_above;
      if (load_above)
      begin
         next_r.hold_cnt = '0;
      end
      else if (r.load_prev)
      begin
         // Falling load reloads the full hold
         next_r.hold_cnt = HOLD_CYCLES;
      end
      else if (r.hold_cnt != '0)
      begin
         next_r.hold_cnt = r.hold_cnt - 36'h0_0000_0001;
      end
      next_r.perm = load_above | r.load_prev | (r.hold_cnt != '0);
      start = arm & lof & next_r.perm;
      unique case (r.state)
         tmv_pkg::TMV_IDLE:
         begin
            if (start)
            begin
               next_r.state = tmv_pkg::TMV_DELAY;
            end
            next_r.dly_cnt = '0;
         end
         tmv_pkg::TMV_DELAY:
         begin
            if (!start)
            begin
               next_r.state = tmv_pkg::TMV_IDLE;
               next_r.dly_cnt = '0;
            end
            else if (r.dly_cnt + 32'h0000_0001 >= delay)
            begin
               next_r.state = tmv_pkg::TMV_FIRED;
            end
            else
            begin
               next_r.dly_cnt = r.dly_cnt + 32'h0000_0001;
            end
         end
         tmv_pkg::TMV_FIRED:
         begin
            // Drives drop once the condition clears
            if (!start)
            begin
               next_r.state = tmv_pkg::TMV_IDLE;
               next_r.dly_cnt = '0;
            end
         end
         default:
         begin
            // Illegal code falls back safe
            next_r.state = tmv_pkg::TMV_IDLE;
         end
      endcase
      next_r.fire = (next_r.state == tmv_pkg::TMV_FIRED);
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
// Top: three controllers, APB registers, interrupt and drives
module tmv_voter
#(
   parameter tmv_pkg::tmv_hold_t HOLD_CYCLES = 36'(`TMV_HOLD_CYC)
)
(
   input  wire logic                clk_sys,
   input  wire logic                rst_b,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic                     irq,
   input  wire tmv_pkg::tmv_level_t level_sg0 [3],
   input  wire tmv_pkg::tmv_level_t level_sg1 [3],
   input  wire tmv_pkg::tmv_level_t level_sg2 [3],
   input  wire tmv_pkg::tmv_level_t first_stage_pressure_a,
   input  wire tmv_pkg::tmv_level_t first_stage_pressure_b,
   output logic                     turbine_trip,
   output logic [2:0]               feed_pump_start,
   output logic                     blowdown_close,
   output logic                     sample_close,
   output logic [1:0]               mg_breaker_trip
);
   tmv_pkg::tmv_top_s r;        // Registered state
   tmv_pkg::tmv_top_s next_r;   // Next state
   logic [2:0]  sg_low;         // Generator low votes
   logic [2:0]  perm;           // Per controller permissive
   logic [2:0]  fire;           // Per controller fire
   logic        lof;            // Loss of feedwater vote
   logic        any_fire;       // Any controller fired
   logic        any_perm;       // Any permissive
   logic        setup;          // APB setup cycle
   logic        acc;            // APB completing access
   logic [31:0] rd;             // Read mux
   logic        hit;            // Mapped address
   logic [2:0]  ev;             // Events this cycle

   assign lof = (sg_low[0] & sg_low[1]) | (sg_low[0] & sg_low[2])
              | (sg_low[1] & sg_low[2]);
   assign any_fire = |fire;
   assign any_perm = |perm;

   // each sees its levels and both pressures
   tmv_sg_ctrl #(.HOLD_CYCLES(HOLD_CYCLES)) u_sg0
   (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .lvl_a     (level_sg0[0]),
      .lvl_b     (level_sg0[1]),
      .lvl_c     (level_sg0[2]),
      .level_thr (r.level_thr),
      .first_stage_pressure_a (first_stage_pressure_a),
      .first_stage_pressure_b (first_stage_pressure_b),
      .load_thr  (r.load_thr),
      .delay     (r.delay),
      .arm       (r.arm),
      .lof       (lof),
      .sg_low    (sg_low[0]),
      .perm      (perm[0]),
      .fire      (fire[0])
   );
   tmv_sg_ctrl #(.HOLD_CYCLES(HOLD_CYCLES)) u_sg1
   (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .lvl_a     (level_sg1[0]),
      .lvl_b     (level_sg1[1]),
      .lvl_c     (level_sg1[2]),
      .level_thr (r.level_thr),
      .first_stage_pressure_a (first_stage_pressure_a),
      .first_stage_pressure_b (first_stage_pressure_b),
      .load_thr  (r.load_thr),
      .delay     (r.delay),
      .arm       (r.arm),
      .lof       (lof),
      .sg_low    (sg_low[1]),
      .perm      (perm[1]),
      .fire      (fire[1])
   );
   tmv_sg_ctrl #(.HOLD_CYCLES(HOLD_CYCLES)) u_sg2
   (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .lvl_a     (level_sg2[0]),
      .lvl_b     (level_sg2[1]),
      .lvl_c     (level_sg2[2]),
      .level_thr (r.level_thr),
      .first_stage_pressure_a (first_stage_pressure_a),
      .first_stage_pressure_b (first_stage_pressure_b),
      .load_thr  (r.load_thr),
      .delay     (r.delay),
      .arm       (r.arm),
      .lof       (lof),
      .sg_low    (sg_low[2]),
      .perm      (perm[2]),
      .fire      (fire[2])
   );

   // Ports come straight from the state flops
   assign prdata          = r.prdata;
   assign pready          = r.pready;
   assign pslverr         = r.pslverr;
   assign irq             = r.irq;
   assign turbine_trip    = r.turbine_trip;
   assign feed_pump_start = r.feed_pump_start;
   assign blowdown_close  = r.blowdown_close;
   assign sample_close    = r.sample_close;
   assign mg_breaker_trip = r.mg_breaker_trip;

   // Bus phases; pready is raised one cycle after setup
   assign setup = psel & ~penable;
   assign acc   = psel & penable & r.pready;

   // Read mux; sticky read adds this cycle's events, else the clear would lose them
   always_comb
   begin
      rd  = '0;
      hit = 1'b1;
      unique case (paddr)
         `TMV_OFF_CTRL:      rd[0] = r.arm;
         `TMV_OFF_LEVEL_THR: rd[15:0] = r.level_thr;
         `TMV_OFF_LOAD_THR:  rd[15:0] = r.load_thr;
         `TMV_OFF_DELAY:     rd = r.delay;
         `TMV_OFF_STATUS:    rd[7:0] = {r.arm, sg_low, any_fire, |r.feed_pump_start,
                                        any_perm, lof};
         `TMV_OFF_IRQ_STAT:  rd[2:0] = r.irq_stat | ev;
         `TMV_OFF_IRQ_MASK:  rd[2:0] = r.irq_mask;
         default:            hit = 1'b0;
      endcase
   end

   // Events: vote rises, drives fire, permissive lost
   assign ev[`TMV_IRQ_LOF]   = lof & ~r.prev_lof;
   assign ev[`TMV_IRQ_FIRE]  = any_fire & ~r.prev_fire;
   assign ev[`TMV_IRQ_BLOCK] = ~any_perm & r.prev_perm;

   // Next state of registers, bus answer and drives
   always_comb
   begin
      next_r = r;
      next_r.prev_lof  = lof;
      next_r.prev_fire = any_fire;
      next_r.prev_perm = any_perm;
      // Answer is prepared in setup, presented in access
      next_r.pready = setup;
      if (setup)
      begin
         next_r.prdata  = pwrite ? 32'h0000_0000 : rd;
         next_r.pslverr = ~hit;
      end
      else if (acc)
      begin
         next_r.prdata  = '0;
         next_r.pslverr = 1'b0;
      end
      // Writes land only at the completing edge
      if (acc && pwrite && hit)
      begin
         unique case (paddr)
            `TMV_OFF_CTRL:      next_r.arm = pwdata[0];
            `TMV_OFF_LEVEL_THR: next_r.level_thr = pwdata[15:0];
            `TMV_OFF_LOAD_THR:  next_r.load_thr = pwdata[15:0];
            `TMV_OFF_DELAY:     next_r.delay = pwdata;
            `TMV_OFF_IRQ_MASK:  next_r.irq_mask = pwdata[2:0];
            default:            next_r.arm = r.arm;
         endcase
      end
      // Read clears the sticky bits; a new event wins
      if (acc && !pwrite && paddr == `TMV_OFF_IRQ_STAT)
      begin
         next_r.irq_stat = ev;
      end
      else
      begin
         next_r.irq_stat = r.irq_stat | ev;
      end
      next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
      next_r.turbine_trip    = any_fire;
      next_r.feed_pump_start = {3{any_fire}};
      next_r.blowdown_close  = any_fire;
      next_r.sample_close    = any_fire;
      next_r.mg_breaker_trip = {2{any_fire}};
   end

   // State register with constant reset values
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         r           <= '0;
         r.arm       <= `TMV_RST_ARM;
         r.level_thr <= `TMV_RST_LEVEL_THR;
         r.load_thr  <= `TMV_RST_LOAD_THR;
         r.delay     <= `TMV_RST_DELAY;
         r.irq_mask  <= `TMV_RST_MASK;
      end
      else
      begin
         r <= next_r;
      end
   end
endmodule

/* File: verification/tb.sv */
// Testbench of the voter: bus tasks and channel scenarios
`timescale 1ns/1ps
`include "tmv_defs.svh"
module tb;
   logic                clk_sys = 1'b0;
   logic                rst_b   = 1'b0;
   logic                psel    = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite  = 1'b0;
   logic [11:0]         paddr   = 12'h000;
   logic [31:0]         pwdata  = 32'h0000_0000;
   logic [31:0]         prdata;
   logic                pready, pslverr, irq, turbine_trip, blowdown_close, sample_close;
   logic [2:0]          feed_pump_start;
   logic [1:0]          mg_breaker_trip;
   logic [8:0]          low_mask = 9'h000;
   logic [1:0]          load_hi  = 2'h3;
   tmv_pkg::tmv_level_t level_sg0 [3], level_sg1 [3], level_sg2 [3];
   tmv_pkg::tmv_level_t first_stage_pressure_a, first_stage_pressure_b;
   int                  fails = 0, num_checks = 0;
   logic [31:0]         d;
   logic                e;
   // Pressure channels above threshold and low level channels of each case
   logic [1:0]          case_load [5] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h2};
   logic [8:0]          case_low [5] = '{9'h01B, 9'h054, 9'h007, 9'h0C3, 9'h146};
   logic                expect_fire [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   always #4 clk_sys = ~clk_sys;
   tmv_plant u_plant (.low_mask(low_mask), .load_hi(load_hi), .level_sg0(level_sg0),
      .level_sg1(level_sg1), .level_sg2(level_sg2),
      .first_stage_pressure_a(first_stage_pressure_a),
      .first_stage_pressure_b(first_stage_pressure_b));
   tmv_voter #(.HOLD_CYCLES(36'h0_0000_0032)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .level_sg0(level_sg0), .level_sg1(level_sg1), .level_sg2(level_sg2),
      .first_stage_pressure_a(first_stage_pressure_a),
      .first_stage_pressure_b(first_stage_pressure_b), .turbine_trip(turbine_trip),
      .feed_pump_start(feed_pump_start), .blowdown_close(blowdown_close),
      .sample_close(sample_close), .mg_breaker_trip(mg_breaker_trip));
   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // One bus transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= w;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
      end
      while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex, input logic er);
      apb(1'b0, a, 32'h0000_0000);
      chk("prdata", ex, d);
      chk("pslverr", {31'h0, er}, {31'h0, e});
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Hang guard, well beyond the run of about four hundred cycles
   initial
   begin
      #40000;
      fails++;
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      cyc(10);
      rst_b <= 1'b1;
      rd_chk(`TMV_OFF_CTRL, 32'h0000_0001, 1'b0);
      rd_chk(`TMV_OFF_LEVEL_THR, 32'h0000_2000, 1'b0);
      rd_chk(`TMV_OFF_LOAD_THR, 32'h0000_6000, 1'b0);
      rd_chk(`TMV_OFF_DELAY, 32'h0000_0400, 1'b0);
      rd_chk(`TMV_OFF_IRQ_MASK, 32'h0000_0000, 1'b0);
      rd_chk(12'h01C, 32'h0000_0000, 1'b1);
      apb(1'b1, `TMV_OFF_DELAY, 32'h0000_000A);
      // Voting patterns, either pressure channel enough
      for (int i = 0; i < 5; i++)
      begin
         load_hi <= case_load[i];
         low_mask <= case_low[i];
         cyc(6);
         chk("trip early", 32'h0, turbine_trip);
         cyc(14);
         chk("trip vote", {31'h0, expect_fire[i]}, turbine_trip);
         low_mask <= 9'h000;
         cyc(4);
         chk("trip clear", 32'h0, turbine_trip);
      end
      // Masked then unmasked interrupt, cleared by reading
      apb(1'b0, `TMV_OFF_IRQ_STAT, 32'h0000_0000);
      low_mask <= 9'h01B;
      cyc(20);
      chk("irq masked", 32'h0, irq);
      apb(1'b1, `TMV_OFF_IRQ_MASK, 32'h0000_0007);
      cyc(2);
      chk("irq", 32'h1, irq);
      rd_chk(`TMV_OFF_IRQ_STAT, 32'h0000_0003, 1'b0);
      cyc(2);
      chk("irq cleared", 32'h0, irq);
      rd_chk(`TMV_OFF_IRQ_STAT, 32'h0000_0000, 1'b0);
      // Disarm drops the drives, rearm restores them
      apb(1'b1, `TMV_OFF_CTRL, 32'h0000_0000);
      cyc(20);
      chk("trip disarmed", 32'h0, turbine_trip);
      apb(1'b1, `TMV_OFF_CTRL, 32'h0000_0001);
      cyc(20);
      chk("trip rearmed", 32'h1, turbine_trip);
      low_mask <= 9'h000;
      cyc(4);
      // Short gap in the vote restarts the delay
      low_mask <= 9'h01B;
      cyc(8);
      low_mask <= 9'h000;
      cyc(2);
      low_mask <= 9'h01B;
      cyc(8);
      chk("trip restart", 32'h0, turbine_trip);
      cyc(12);
      chk("trip after", 32'h1, turbine_trip);
      low_mask <= 9'h000;
      // Vote inside the hold after load drop still fires
      load_hi <= 2'h0;
      cyc(3);
      low_mask <= 9'h01B;
      cyc(20);
      chk("trip hold", 32'h1, turbine_trip);
      low_mask <= 9'h000;
      cyc(60);
      low_mask <= 9'h01B;
      cyc(20);
      chk("trip blocked", 32'h0, turbine_trip);
      // Vote seen, permissive gone, arm kept: 0xB1
      rd_chk(`TMV_OFF_STATUS, 32'h0000_00B1, 1'b0);
      chk("irq block", 32'h1, irq);
      // Vote, fire and permissive loss all latched since the last read
      rd_chk(`TMV_OFF_IRQ_STAT, 32'h0000_0007, 1'b0);
      low_mask <= 9'h000;
      report_and_stop();
   end
endmodule

/* File: verification/tmv_plant.sv */
// Model of the transmitters: level and pressure channels from masks
`timescale 1ns/1ps
module tmv_plant
#(
   parameter tmv_pkg::tmv_level_t LVL_THR  = 16'h2000,
   parameter tmv_pkg::tmv_level_t LOAD_THR = 16'h6000
)
(
   input  wire logic [8:0]          low_mask,
   input  wire logic [1:0]          load_hi,
   output tmv_pkg::tmv_level_t      level_sg0 [3],
   output tmv_pkg::tmv_level_t      level_sg1 [3],
   output tmv_pkg::tmv_level_t      level_sg2 [3],
   output tmv_pkg::tmv_level_t      first_stage_pressure_a,
   output tmv_pkg::tmv_level_t      first_stage_pressure_b
);
   ////////////////////////////////////////////////////////////////////////
   // three levels per generator, low sits exactly on threshold
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         level_sg0[i] = low_mask[i] ? LVL_THR : LVL_THR + 16'h0001;
         level_sg1[i] = low_mask[3+i] ? LVL_THR : LVL_THR + 16'h0001;
         level_sg2[i] = low_mask[6+i] ? LVL_THR : LVL_THR + 16'h0001;
      end
      // two pressure channels, low equals threshold
      first_stage_pressure_a = load_hi[0] ? LOAD_THR + 16'h0001 : LOAD_THR;
      first_stage_pressure_b = load_hi[1] ? LOAD_THR + 16'h0001 : LOAD_THR;
   end
endmodule

/* File: verification/tmv_voter_sva.sv */
// Checker for the voter top: bus answer timing and drive grouping
`timescale 1ns/1ps
module tmv_voter_chk
(
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   input wire logic        turbine_trip,
   input wire logic [2:0]  feed_pump_start,
   input wire logic        blowdown_close,
   input wire logic        sample_close,
   input wire logic [1:0]  mg_breaker_trip
);
   ////////////////////////////////////////////////////////////////////////
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // A fired controller raises every drive at once
   property p_all_drives;
      turbine_trip |-> feed_pump_start == 3'h7 && blowdown_close && sample_close
         && mg_breaker_trip == 2'h3;
   endproperty
   a_all_drives: assert property (p_all_drives)
      else $error("drives not raised together");
   // No partial drive may stand while the turbine trip is low
   property p_no_drives;
      !turbine_trip |-> feed_pump_start == 3'h0 && !blowdown_close && !sample_close
         && mg_breaker_trip == 2'h0;
   endproperty
   a_no_drives: assert property (p_no_drives)
      else $error("drive high without turbine trip");
   // Every setup gets its answer in the very next cycle
   property p_ready_next;
      psel && !penable |=> pready;
   endproperty
   a_ready_next: assert property (p_ready_next)
      else $error("pready missing after setup");
   // Answer stands a single cycle
   property p_ready_once;
      pready |=> !pready;
   endproperty
   a_ready_once: assert property (p_ready_once)
      else $error("pready longer than one cycle");
   // Answer only inside an access phase that followed a setup
   property p_ready_access;
      pready |-> psel && penable && $past(psel && !penable);
   endproperty
   a_ready_access: assert property (p_ready_access)
      else $error("pready outside access phase");
   // Error flag only rides on an answer
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready)
      else $error("pslverr without pready");
   // Refused reads carry no data
   property p_err_data;
      pslverr |-> prdata == 32'h0000_0000;
   endproperty
   a_err_data: assert property (p_err_data)
      else $error("prdata not zero on error");
   // Drives rise only after the turbine trip stood low two cycles before
   property p_rise_late;
      $rose(turbine_trip) |-> $past(!turbine_trip, 2);
   endproperty
   a_rise_late: assert property (p_rise_late)
      else $error("drives rose without delay");
endmodule
bind tmv_voter tmv_voter_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .turbine_trip(turbine_trip), .feed_pump_start(feed_pump_start),
   .blowdown_close(blowdown_close), .sample_close(sample_close),
   .mg_breaker_trip(mg_breaker_trip));
